// ===== hw/usrr_axil_slave.sv
// AXI4-Lite slave that turns bus transfers into single-cycle register accesses.
`timescale 1ns/1ps
module usrr_axil_slave
    import usrr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [USRR_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [USRR_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    usrr_regbus_if.slave bus
);

    logic wr_fire;
    logic [USRR_ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    // The write fires once both address and data are held and no response is pending.
    assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign bus.wr_en = wr_fire;
    assign bus.wr_addr = awaddr_q;
    assign bus.wr_data = wdata_q;
    assign bus.wr_strb = wstrb_q;
    assign bus.rd_addr = s_axi_araddr;

    // Write address and data channels are taken independently, in either order.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                s_axi_awready <= 1'b0;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                s_axi_wready <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Write response follows the register access by one cycle.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= USRR_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= bus.wr_hit ? USRR_RESP_OKAY : USRR_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Read data is sampled at the address handshake and held until taken.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= USRR_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= bus.rd_data;
            s_axi_rresp <= bus.rd_hit ? USRR_RESP_OKAY : USRR_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ===== hw/usrr_launch.sv
// Sequencer that launches an outgoing setup transaction and tracks it to completion.
`timescale 1ns/1ps
module usrr_launch
    import usrr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic go,
    input wire logic tx_done,
    output logic busy_q,
    output logic start_q,
    output logic done_q
);

    usrr_launch_e state_q;

    // Idle, a one-cycle start pulse, then wait for the engine to finish.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_q <= USRR_L_IDLE;
        else
        begin
            case (state_q)
                USRR_L_IDLE:
                    if (go)
                        state_q <= USRR_L_START;
                USRR_L_START:
                    state_q <= USRR_L_WAIT;
                USRR_L_WAIT:
                    if (tx_done)
                        state_q <= USRR_L_IDLE;
                default:
                    state_q <= USRR_L_IDLE;
            endcase
        end
    end

    // Registered outputs derived from the next state.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            busy_q <= 1'b0;
            start_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            start_q <= (state_q == USRR_L_IDLE) && go;
            done_q <= (state_q == USRR_L_WAIT) && tx_done;
            if ((state_q == USRR_L_IDLE) && go)
                busy_q <= 1'b1;
            else if ((state_q == USRR_L_WAIT) && tx_done)
                busy_q <= 1'b0;
        end
    end

endmodule

// ===== hw/usrr_pkg.sv
// Package of shared constants and types for the setup request register block.
package usrr_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    // Register indices as printed; the byte address is four times the index.
    localparam int USRR_ADDR_W = 10;
    localparam logic [7:0] USRR_IDX_CODE_TYPE = 8'h54;
    localparam logic [7:0] USRR_IDX_VALUE = 8'h56;
    localparam logic [7:0] USRR_IDX_INDEX = 8'h58;
    localparam logic [7:0] USRR_IDX_CTRL = 8'h5a;
    localparam logic [7:0] USRR_IDX_STAT = 8'h5c;
    localparam logic [9:0] USRR_ADDR_CODE_TYPE = {USRR_IDX_CODE_TYPE, 2'h0};
    localparam logic [9:0] USRR_ADDR_VALUE = {USRR_IDX_VALUE, 2'h0};
    localparam logic [9:0] USRR_ADDR_INDEX = {USRR_IDX_INDEX, 2'h0};
    localparam logic [9:0] USRR_ADDR_CTRL = {USRR_IDX_CTRL, 2'h0};
    localparam logic [9:0] USRR_ADDR_STAT = {USRR_IDX_STAT, 2'h0};

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int USRR_CODE_LSB = 8;
    localparam int USRR_TYPE_LSB = 0;
    localparam int USRR_CTRL_HOST_BIT = 0;
    localparam int USRR_CTRL_SEND_BIT = 1;
    localparam int USRR_STAT_RX_BIT = 0;
    localparam int USRR_STAT_DONE_BIT = 1;
    localparam logic [15:0] USRR_RST_CODE_TYPE = 16'h0000;
    localparam logic [15:0] USRR_RST_VALUE = 16'h0000;
    localparam logic [15:0] USRR_RST_INDEX = 16'h0000;
    localparam logic [1:0] USRR_RESP_OKAY = 2'h0;
    localparam logic [1:0] USRR_RESP_SLVERR = 2'h2;

    // ****************************************************************
    // Types and helpers
    // ****************************************************************
    typedef enum logic [1:0] {
        USRR_L_IDLE = 2'h0,
        USRR_L_START = 2'h1,
        USRR_L_WAIT = 2'h3
    } usrr_launch_e;

    // Merges a bus word into a 16-bit register under its two low byte enables.
    function automatic logic [15:0] usrr_merge(input logic [15:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [15:0] res;
        res = old;
        if (strb[0])
            res[7:0] = data[7:0];
        if (strb[1])
            res[15:8] = data[15:8];
        return res;
    endfunction

endpackage

// ===== hw/usrr_regbus_if.sv
// Interface that carries register accesses from the bus slave to the register file.
`timescale 1ns/1ps
interface usrr_regbus_if #(parameter int AW = 10);
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_hit;
    logic [AW-1:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_hit;

    modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                   input wr_hit, rd_data, rd_hit);
    modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                  output wr_hit, rd_data, rd_hit);
endinterface

// ===== hw/usrr_top.sv
// Setup request registers of a dual-role USB controller with an AXI4-Lite register port.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
module usrr_top
    import usrr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [USRR_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [USRR_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_setup_valid,
    input wire logic [63:0] rx_setup_packet,
    input wire logic tx_setup_done,
    output logic tx_setup_start,
    output logic setup_send_request,
    output logic host_role,
    output logic [15:0] tx_code_type,
    output logic [15:0] tx_value,
    output logic [15:0] tx_index
);

    // ****************************************************************
    // Internal signals
    // ****************************************************************
    usrr_regbus_if #(.AW(USRR_ADDR_W)) bus ();

    logic host_role_q;
    logic [15:0] code_type_q;
    logic [15:0] value_q;
    logic [15:0] index_q;
    logic rx_flag_q;
    logic done_flag_q;
    logic send_busy;
    logic send_done;
    logic rx_capture;
    logic field_wr;
    logic ctrl_wr;
    logic stat_wr;
    logic launch_go;

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    // The slave holds every AXI output in a flip-flop.
    usrr_axil_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .bus(bus)
    );

    // ****************************************************************
    // Setup launch sequencer
    // ****************************************************************
    // Its busy flag is the send request bit that software polls.
    usrr_launch u_launch (
        .aclk(aclk),
        .aresetn(aresetn),
        .go(launch_go),
        .tx_done(tx_setup_done),
        .busy_q(send_busy),
        .start_q(tx_setup_start),
        .done_q(send_done)
    );

    // ****************************************************************
    // Access decoding
    // ****************************************************************
    // A received setup is only taken while the controller acts as a peripheral.
    assign rx_capture = rx_setup_valid && !host_role_q;
    // Field writes count only in host role and while no setup is in flight.
    assign field_wr = bus.wr_en && host_role_q && !send_busy;
    assign ctrl_wr = bus.wr_en && (bus.wr_addr == USRR_ADDR_CTRL) && bus.wr_strb[0];
    assign stat_wr = bus.wr_en && (bus.wr_addr == USRR_ADDR_STAT) && bus.wr_strb[0];
    // Writing one to the send bit in host role starts a transaction.
    assign launch_go = ctrl_wr && host_role_q && !send_busy
                       && bus.wr_data[USRR_CTRL_SEND_BIT];

    // Write hit decode for the response code.
    always_comb
    begin
        if (bus.wr_addr == USRR_ADDR_CODE_TYPE)
            bus.wr_hit = 1'b1;
        else if (bus.wr_addr == USRR_ADDR_VALUE)
            bus.wr_hit = 1'b1;
        else if (bus.wr_addr == USRR_ADDR_INDEX)
            bus.wr_hit = 1'b1;
        else if (bus.wr_addr == USRR_ADDR_CTRL)
            bus.wr_hit = 1'b1;
        else if (bus.wr_addr == USRR_ADDR_STAT)
            bus.wr_hit = 1'b1;
        else
            bus.wr_hit = 1'b0;
    end

    // ****************************************************************
    // Request code and type register
    // ****************************************************************
    // Hardware capture in peripheral role; software write only in host role.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            code_type_q <= USRR_RST_CODE_TYPE;
        else if (rx_capture)
        begin
            code_type_q[USRR_CODE_LSB +: 8] <= rx_setup_packet[15:8];
            code_type_q[USRR_TYPE_LSB +: 8] <= rx_setup_packet[7:0];
        end
        else if (field_wr && (bus.wr_addr == USRR_ADDR_CODE_TYPE))
            code_type_q <= usrr_merge(code_type_q, bus.wr_data, bus.wr_strb);
    end

    // ****************************************************************
    // Request value register
    // ****************************************************************
    // Low byte of the value travels first on the bus and lands in bits 7-0.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            value_q <= USRR_RST_VALUE;
        else if (rx_capture)
            value_q <= rx_setup_packet[31:16];
        else if (field_wr && (bus.wr_addr == USRR_ADDR_VALUE))
            value_q <= usrr_merge(value_q, bus.wr_data, bus.wr_strb);
    end

    // ****************************************************************
    // Request index register
    // ****************************************************************
    // Resets to zero; same role split as the other fields.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            index_q <= USRR_RST_INDEX;
        else if (rx_capture)
            index_q <= rx_setup_packet[47:32];
        else if (field_wr && (bus.wr_addr == USRR_ADDR_INDEX))
            index_q <= usrr_merge(index_q, bus.wr_data, bus.wr_strb);
    end

    // ****************************************************************
    // Control and status
    // ****************************************************************
    // The role may not change while a setup is in flight.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            host_role_q <= 1'b0;
        else if (ctrl_wr && !send_busy)
            host_role_q <= bus.wr_data[USRR_CTRL_HOST_BIT];
    end

    // Sticky event flags cleared by writing one; a new event beats the clear.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_flag_q <= 1'b0;
            done_flag_q <= 1'b0;
        end
        else
        begin
            if (rx_capture)
                rx_flag_q <= 1'b1;
            else if (stat_wr && bus.wr_data[USRR_STAT_RX_BIT])
                rx_flag_q <= 1'b0;
            if (send_done)
                done_flag_q <= 1'b1;
            else if (stat_wr && bus.wr_data[USRR_STAT_DONE_BIT])
                done_flag_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Read multiplexer
    // ****************************************************************
    // Unused upper bits read as zero; unmapped addresses answer with an error.
    always_comb
    begin
        bus.rd_data = 32'h0000_0000;
        bus.rd_hit = 1'b1;
        if (bus.rd_addr == USRR_ADDR_CODE_TYPE)
            bus.rd_data[15:0] = code_type_q;
        else if (bus.rd_addr == USRR_ADDR_VALUE)
            bus.rd_data[15:0] = value_q;
        else if (bus.rd_addr == USRR_ADDR_INDEX)
            bus.rd_data[15:0] = index_q;
        else if (bus.rd_addr == USRR_ADDR_CTRL)
        begin
            bus.rd_data[USRR_CTRL_HOST_BIT] = host_role_q;
            bus.rd_data[USRR_CTRL_SEND_BIT] = send_busy;
        end
        else if (bus.rd_addr == USRR_ADDR_STAT)
        begin
            bus.rd_data[USRR_STAT_RX_BIT] = rx_flag_q;
            bus.rd_data[USRR_STAT_DONE_BIT] = done_flag_q;
        end
        else
            bus.rd_hit = 1'b0;
    end

    // ****************************************************************
    // Outputs to the transaction engine
    // ****************************************************************
    // The engine reads the fields only while the send bit is set.
    assign setup_send_request = send_busy;
    assign host_role = host_role_q;
    assign tx_code_type = code_type_q;
    assign tx_value = value_q;
    assign tx_index = index_q;

endmodule

// ===== tb/usrr_checker.sv
// Concurrent checks on the ports of the setup request register block.
`timescale 1ns/1ps
module usrr_checker
    import usrr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic rx_setup_valid,
    input wire logic [63:0] rx_setup_packet,
    input wire logic tx_setup_done,
    input wire logic tx_setup_start,
    input wire logic setup_send_request,
    input wire logic host_role,
    input wire logic [15:0] tx_code_type,
    input wire logic [15:0] tx_value,
    input wire logic [15:0] tx_index
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // A launch is a one-cycle start with the send bit raised in host role.
    sequence s_launch;
        setup_send_request && host_role ##1 !tx_setup_start && setup_send_request;
    endsequence
    property p_launch;
        $rose(tx_setup_start) |-> s_launch;
    endproperty
    a_launch: assert property (p_launch) else $error("bad launch pulse");
    property p_send_rise;
        $rose(setup_send_request) |-> tx_setup_start;
    endproperty
    a_send_rise: assert property (p_send_rise) else $error("send set without start");
    property p_send_fall;
        $fell(setup_send_request) |-> $past(tx_setup_done) || $past(tx_setup_done, 2);
    endproperty
    a_send_fall: assert property (p_send_fall) else $error("send cleared early");
    property p_rx_code;
        logic [63:0] pk;
        (rx_setup_valid && !host_role, pk = rx_setup_packet) |=> tx_code_type == pk[15:0];
    endproperty
    a_rx_code: assert property (p_rx_code) else $error("code/type not loaded");
    property p_rx_value;
        logic [63:0] pk;
        (rx_setup_valid && !host_role, pk = rx_setup_packet) |=> tx_value == pk[31:16];
    endproperty
    a_rx_value: assert property (p_rx_value) else $error("value not loaded");
    property p_rx_index;
        logic [63:0] pk;
        (rx_setup_valid && !host_role, pk = rx_setup_packet) |=> tx_index == pk[47:32];
    endproperty
    a_rx_index: assert property (p_rx_index) else $error("index not loaded");
    property p_busy_hold;
        setup_send_request |-> $stable(tx_code_type) && $stable(tx_value) && $stable(tx_index);
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("field moved while busy");
    property p_peri_hold;
        !host_role && !rx_setup_valid |=> $stable(tx_code_type) && $stable(tx_value)
            && $stable(tx_index);
    endproperty
    a_peri_hold: assert property (p_peri_hold) else $error("field moved in peripheral");
endmodule

bind usrr_top usrr_checker chk (.aclk, .aresetn, .rx_setup_valid, .rx_setup_packet,
    .tx_setup_done, .tx_setup_start, .setup_send_request, .host_role, .tx_code_type,
    .tx_value, .tx_index);

// ===== tb/usrr_far_end.sv
// Model of the far-side setup engine and of the remote peer that sends setups.
`timescale 1ns/1ps
module usrr_far_end (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tx_setup_start,
    input wire logic [7:0] done_delay,
    input wire logic rx_req,
    input wire logic [63:0] rx_data,
    output logic tx_setup_done,
    output logic rx_setup_valid,
    output logic [63:0] rx_setup_packet
);
    logic [8:0] cnt_q;

    // Finishes each launched setup after the chosen number of cycles, with a one-cycle done.
    always_ff @(posedge aclk)
    begin
        tx_setup_done <= 1'b0;
        if (!aresetn)
            cnt_q <= 9'h000;
        else if (tx_setup_start)
            cnt_q <= {1'b1, done_delay};
        else if (cnt_q == 9'h100)
        begin
            tx_setup_done <= 1'b1;
            cnt_q <= 9'h000;
        end
        else if (cnt_q[8])
            cnt_q <= cnt_q - 9'h001;
    end

    // Delivers a received setup; between setups the packet lines toggle so stale bytes show.
    always_ff @(posedge aclk)
    begin
        rx_setup_valid <= aresetn && rx_req;
        rx_setup_packet <= rx_req ? rx_data : ~rx_setup_packet;
    end
endmodule

// ===== tb/usrr_top_bench.sv
// Self-checking bench for the setup request register block.
`timescale 1ns/1ps
module usrr_top_bench
    import usrr_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [9:0] s_axi_awaddr = '0;
    logic [9:0] s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic rx_setup_valid, tx_setup_done, tx_setup_start, setup_send_request, host_role;
    logic [63:0] rx_setup_packet;
    logic [15:0] tx_code_type, tx_value, tx_index;
    logic [7:0] done_delay = 8'h00;
    logic rx_req = 1'b0;
    logic [63:0] rx_data = '0;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    typedef struct packed {
        logic [9:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
        logic [31:0] exp;
    } usrr_row_s;
    usrr_row_s rows [5] = '{
        '{USRR_ADDR_CODE_TYPE, 32'h0000a1b2, 4'h3, 32'h0000a1b2},
        '{USRR_ADDR_VALUE, 32'hdead5678, 4'hf, 32'h00005678},
        '{USRR_ADDR_INDEX, 32'h0000ffff, 4'h1, 32'h000000ff},
        '{USRR_ADDR_INDEX, 32'h00001100, 4'h2, 32'h000011ff},
        '{USRR_ADDR_VALUE, 32'h000099aa, 4'h0, 32'h00005678}};

    usrr_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_setup_valid, .rx_setup_packet,
        .tx_setup_done, .tx_setup_start, .setup_send_request, .host_role, .tx_code_type,
        .tx_value, .tx_index);
    usrr_far_end peer (.aclk, .aresetn, .tx_setup_start, .done_delay, .rx_req, .rx_data,
        .tx_setup_done, .rx_setup_valid, .rx_setup_packet);

    // ****************************************************************
    // Clock, watchdog and shared tasks
    // ****************************************************************
    always #12.5 aclk = ~aclk;

    // Cuts a hung run short well after the expected length.
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            failures++;
            test_done();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check(32'(s_axi_bresp), 32'(er));
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] ex, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, ex);
        check(32'(s_axi_rresp), 32'(er));
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(USRR_ADDR_CODE_TYPE, 32'h0, USRR_RESP_OKAY);
        rd(USRR_ADDR_INDEX, 32'h0, USRR_RESP_OKAY);
        rd(USRR_ADDR_CTRL, 32'h0, USRR_RESP_OKAY);
        rd(10'h004, 32'h0, USRR_RESP_SLVERR);
        wr(10'h004, 32'hffff, 4'hf, USRR_RESP_SLVERR);
        wr(USRR_ADDR_VALUE, 32'h1234, 4'h3, USRR_RESP_OKAY);
        rd(USRR_ADDR_VALUE, 32'h0, USRR_RESP_OKAY);
        wr(USRR_ADDR_CTRL, 32'h1, 4'h1, USRR_RESP_OKAY);
        foreach (rows[i])
        begin
            wr(rows[i].addr, rows[i].data, rows[i].strb, USRR_RESP_OKAY);
            rd(rows[i].addr, rows[i].exp, USRR_RESP_OKAY);
        end
        check(32'(tx_index), 32'h11ff);
        // Slow launch: field and role writes are held off while busy.
        done_delay <= 8'h3c;
        wr(USRR_ADDR_CTRL, 32'h3, 4'h1, USRR_RESP_OKAY);
        @(negedge aclk);
        check(32'(setup_send_request), 32'h1);
        wr(USRR_ADDR_VALUE, 32'hbeef, 4'h3, USRR_RESP_OKAY);
        wr(USRR_ADDR_CODE_TYPE, 32'h1111, 4'h3, USRR_RESP_OKAY);
        wr(USRR_ADDR_INDEX, 32'h2222, 4'h3, USRR_RESP_OKAY);
        wr(USRR_ADDR_CTRL, 32'h0, 4'h1, USRR_RESP_OKAY);
        rd(USRR_ADDR_CTRL, 32'h3, USRR_RESP_OKAY);
        rd(USRR_ADDR_VALUE, 32'h5678, USRR_RESP_OKAY);
        rd(USRR_ADDR_CODE_TYPE, 32'ha1b2, USRR_RESP_OKAY);
        rd(USRR_ADDR_INDEX, 32'h11ff, USRR_RESP_OKAY);
        while (setup_send_request)
            @(posedge aclk);
        rd(USRR_ADDR_STAT, 32'h2, USRR_RESP_OKAY);
        wr(USRR_ADDR_STAT, 32'h2, 4'h1, USRR_RESP_OKAY);
        rd(USRR_ADDR_STAT, 32'h0, USRR_RESP_OKAY);
        // Prompt launch answered at once by the engine.
        done_delay <= 8'h00;
        wr(USRR_ADDR_CTRL, 32'h3, 4'h1, USRR_RESP_OKAY);
        // The send bit rises with the write response, an edge before the write returns; one more edge passes first.
        @(posedge aclk);
        while (setup_send_request)
            @(posedge aclk);
        rd(USRR_ADDR_CTRL, 32'h1, USRR_RESP_OKAY);
        // Peripheral role: a received setup fills the fields, software cannot.
        wr(USRR_ADDR_CTRL, 32'h0, 4'h1, USRR_RESP_OKAY);
        rx_data <= 64'hffff_4321_8765_0680;
        rx_req <= 1'b1;
        @(posedge aclk);
        rx_req <= 1'b0;
        repeat (2) @(posedge aclk);
        rd(USRR_ADDR_CODE_TYPE, 32'h0680, USRR_RESP_OKAY);
        rd(USRR_ADDR_VALUE, 32'h8765, USRR_RESP_OKAY);
        rd(USRR_ADDR_INDEX, 32'h4321, USRR_RESP_OKAY);
        rd(USRR_ADDR_STAT, 32'h3, USRR_RESP_OKAY);
        wr(USRR_ADDR_CODE_TYPE, 32'h5555, 4'h3, USRR_RESP_OKAY);
        wr(USRR_ADDR_CTRL, 32'h2, 4'h1, USRR_RESP_OKAY);
        rd(USRR_ADDR_CODE_TYPE, 32'h0680, USRR_RESP_OKAY);
        rd(USRR_ADDR_CTRL, 32'h0, USRR_RESP_OKAY);
        // Reset in mid-run returns the index to zero.
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(USRR_ADDR_INDEX, 32'h0, USRR_RESP_OKAY);
        test_done();
    end
endmodule
